// ### verilog/tacr_config_regs.v
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "tacr_defines.vh"
module tacr_config_regs
(
  input  wire        clk,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire [2:0]  tri_phase_duty_step_three,
  output wire [2:0]  tri_phase_duty_step_four,
  output wire [2:0]  tri_phase_duty_step_five,
  output wire [2:0]  tri_phase_duty_step_six,
  output wire [2:0]  tri_phase_duty_step_seven,
  output wire [13:0] duty_level_three,
  output wire [13:0] duty_level_four,
  output wire [13:0] duty_level_five,
  output wire [13:0] duty_level_six,
  output wire [13:0] duty_level_seven,
  output wire [1:0]  wide_mod_angle_advance,
  output wire [3:0]  advance_degrees,
  output wire [8:0]  upper_duty_steps,
  output wire [1:0]  open_loop_transfer_cycles,
  output wire [4:0]  transfer_cycle_count,
  output wire [2:0]  surge_guard_negative_limit,
  output wire [6:0]  negative_limit_value,
  output wire        surge_guard_hysteresis,
  output wire [4:0]  hysteresis_value,
  output wire [7:0]  positive_limit_value,
  output wire [4:0]  initial_speed_backemf_threshold,
  output wire [12:0] backemf_threshold_value,
  output wire [2:0]  initial_speed_cycle_threshold,
  output wire [4:0]  cycle_threshold_value,
  output wire [1:0]  open_loop_crossing_angle,
  output wire [3:0]  crossing_angle_degrees,
  output wire [1:0]  quick_start_divide,
  output wire [3:0]  divide_value
);
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  localparam SEL_NONE    = 2'h0;
  localparam SEL_PROFILE = 2'h1;
  localparam SEL_ALGO    = 2'h2;

  function [1:0] decode_addr;
    input [11:0] addr;
    begin
      case (addr)
        `TACR_ADDR_PROFILE:   decode_addr = SEL_PROFILE;
        `TACR_ADDR_ALGO_VARS: decode_addr = SEL_ALGO;
        default:              decode_addr = SEL_NONE;
      endcase
    end
  endfunction

  wire [1:0] sel;
  wire       setup;
  wire       access;
  wire       wr_en;

  assign sel    = decode_addr(paddr);
  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign wr_en  = access & pwrite;

  // ----------------------------------------
  // apb handshake
  // ----------------------------------------
  assign pready  = access;
  assign pslverr = access & (sel == SEL_NONE);

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg  [31:0] profile_q;
  reg  [31:0] profile_d;
  reg  [31:0] algo_q;
  reg  [31:0] algo_d;
  reg  [31:0] prdata_q;
  reg  [31:0] prdata_d;

  always @*
  begin
    profile_d = profile_q;
    algo_d    = algo_q;
    if (wr_en && sel == SEL_PROFILE)
    begin
      profile_d = pwdata & `TACR_MASK_PROFILE;
    end
    if (wr_en && sel == SEL_ALGO)
    begin
      algo_d = pwdata & `TACR_MASK_ALGO_VARS;
    end
  end

  always @*
  begin
    case (sel)
      SEL_PROFILE: prdata_d = profile_q & `TACR_MASK_PROFILE;
      SEL_ALGO:    prdata_d = algo_q & `TACR_MASK_ALGO_VARS;
      default:     prdata_d = 32'h00000000;
    endcase
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      profile_q <= `TACR_RESET_PROFILE;
      algo_q    <= `TACR_RESET_ALGO_VARS;
      prdata_q  <= 32'h00000000;
    end
    else
    begin
      profile_q <= profile_d;
      algo_q    <= algo_d;
      if (setup && !pwrite)
      begin
        prdata_q <= prdata_d;
      end
    end
  end

  assign prdata = prdata_q;

  // ----------------------------------------
  // duty step decode
  // ----------------------------------------
  wire [14:0] step_codes;
  wire [69:0] step_levels;

  assign step_codes = profile_q[`TACR_STEP3_LSB + 2:`TACR_CYC_LSB];

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1)
    begin : gen_step
      tacr_duty_decoder u_duty
      (
        .code  (step_codes[12 - 3 * g +: 3]),
        .level (step_levels[14 * g +: 14])
      );
    end
  endgenerate

  // ----------------------------------------
  // algorithm variable decode
  // ----------------------------------------
  wire [4:0]  olc_val;
  wire [6:0]  neg_val;
  wire [4:0]  hyst_val;
  wire [7:0]  pos_val;
  wire [12:0] bemf_val;
  wire [4:0]  cyc_val;
  wire [3:0]  zca_val;
  wire [3:0]  div_val;

  tacr_algo_decoder u_algo
  (
    .algo_vars         (algo_q),
    .transfer_cycles   (olc_val),
    .negative_limit    (neg_val),
    .hysteresis        (hyst_val),
    .positive_limit    (pos_val),
    .backemf_threshold (bemf_val),
    .cycle_threshold   (cyc_val),
    .crossing_angle    (zca_val),
    .divide            (div_val)
  );

  // ----------------------------------------
  // registered decoded values
  // ----------------------------------------
  reg  [69:0] levels_q;
  reg  [3:0]  adv_deg_q;
  reg  [4:0]  olc_q;
  reg  [6:0]  neg_q;
  reg  [4:0]  hyst_q;
  reg  [7:0]  pos_q;
  reg  [12:0] bemf_q;
  reg  [4:0]  cyc_q;
  reg  [3:0]  zca_q;
  reg  [3:0]  div_q;
  wire [1:0]  adv_code;

  assign adv_code = profile_q[`TACR_ADV_LSB +: 2];

  always @(posedge clk)
  begin
    if (reset)
    begin
      levels_q  <= 70'h0;
      adv_deg_q <= 4'h0;
      olc_q     <= `TACR_OLC_BASE;
      neg_q     <= 7'h00;
      hyst_q    <= `TACR_HYST_0;
      pos_q     <= 8'h14;
      bemf_q    <= 13'h0000;
      cyc_q     <= `TACR_CYC_BASE;
      zca_q     <= `TACR_ZCA_0;
      div_q     <= 4'h1;
    end
    else
    begin
      levels_q  <= step_levels;
      adv_deg_q <= {2'h0, adv_code} * `TACR_ADV_STEP;
      olc_q     <= olc_val;
      neg_q     <= neg_val;
      hyst_q    <= hyst_val;
      pos_q     <= pos_val;
      bemf_q    <= bemf_val;
      cyc_q     <= cyc_val;
      zca_q     <= zca_val;
      div_q     <= div_val;
    end
  end

  // ----------------------------------------
  // field outputs
  // ----------------------------------------
  assign tri_phase_duty_step_three = profile_q[21:19];
  assign tri_phase_duty_step_four  = profile_q[18:16];
  assign tri_phase_duty_step_five  = profile_q[15:13];
  assign tri_phase_duty_step_six   = profile_q[12:10];
  assign tri_phase_duty_step_seven = profile_q[9:7];
  assign duty_level_three = levels_q[13:0];
  assign duty_level_four  = levels_q[27:14];
  assign duty_level_five  = levels_q[41:28];
  assign duty_level_six   = levels_q[55:42];
  assign duty_level_seven = levels_q[69:56];
  assign wide_mod_angle_advance = adv_code;
  assign advance_degrees        = adv_deg_q;
  assign upper_duty_steps       = profile_q[30:22];

  assign open_loop_transfer_cycles       = algo_q[`TACR_OLC_LSB +: 2];
  assign transfer_cycle_count            = olc_q;
  assign surge_guard_negative_limit      = algo_q[`TACR_NEG_LSB +: 3];
  assign negative_limit_value            = neg_q;
  assign surge_guard_hysteresis          = algo_q[`TACR_HYST_BIT];
  assign hysteresis_value                = hyst_q;
  assign positive_limit_value            = pos_q;
  assign initial_speed_backemf_threshold = algo_q[`TACR_BEMF_LSB +: 5];
  assign backemf_threshold_value         = bemf_q;
  assign initial_speed_cycle_threshold   = algo_q[`TACR_CYC_LSB +: 3];
  assign cycle_threshold_value           = cyc_q;
  assign open_loop_crossing_angle        = algo_q[`TACR_ZCA_LSB +: 2];
  assign crossing_angle_degrees          = zca_q;
  assign quick_start_divide              = algo_q[`TACR_DIV_LSB +: 2];
  assign divide_value                    = div_q;
endmodule

// ### verilog/tacr_defines.vh
`ifndef TACR_DEFINES_VH
`define TACR_DEFINES_VH
// Overview of operation
// - profile register holds duty steps three to seven at bits 21-19 down to 9-7
// - each duty step code selects 0, 50, 75, 83.75, 87.5, 93.75, 97.5 or 99 percent
// - step four fractional codes map to the same eight duty levels
// - profile bits 6-5 set lead angle advance of 0, 5, 10 or 15 degrees
// - algorithm variable register sits at index 9Ah and resets to zero
// - bits 23-22 select open loop transfer of 3, 6, 12 or 24 cycles
// - bits 18-16 map to negative limit 0, -40, -30, -20, -10, 10, 20, 30
// - bit 15 selects hysteresis 20 or 10; positive limit is hysteresis plus negative
// - bits 14-10 give back-emf threshold of 200 times the code
// - bits 9-7 give cycle threshold of 2 plus 3 times the code
// - bits 3-2 give crossing angle of 5, 8, 12 or 15 degrees
// - bits 1-0 give quick start divide of 1, 2, 4 or 8
// - profile register sits at index 98h and holds parity and steps zero to two

// ----------------------------------------
// register indices and byte addresses
// ----------------------------------------
`define TACR_IDX_PROFILE   12'h098
`define TACR_IDX_ALGO_VARS 12'h09A
`define TACR_ADDR_PROFILE   (`TACR_IDX_PROFILE << 2)
`define TACR_ADDR_ALGO_VARS (`TACR_IDX_ALGO_VARS << 2)
`define TACR_RESET_PROFILE   32'h00000000
`define TACR_RESET_ALGO_VARS 32'h00000000
`define TACR_MASK_PROFILE   32'hFFFFFFE0
`define TACR_MASK_ALGO_VARS 32'h80C7FF8F

// ----------------------------------------
// field positions
// ----------------------------------------
`define TACR_STEP3_LSB   19
`define TACR_STEP_WIDTH  3
`define TACR_ADV_LSB     5
`define TACR_OLC_LSB     22
`define TACR_NEG_LSB     16
`define TACR_HYST_BIT    15
`define TACR_BEMF_LSB    10
`define TACR_CYC_LSB     7
`define TACR_ZCA_LSB     2
`define TACR_DIV_LSB     0
`define TACR_PARITY_BIT  31

// ----------------------------------------
// duty levels in units of 0.01 percent
// ----------------------------------------
`define TACR_DUTY_0 14'h0000
`define TACR_DUTY_1 14'h1388
`define TACR_DUTY_2 14'h1D4C
`define TACR_DUTY_3 14'h20B7
`define TACR_DUTY_4 14'h222E
`define TACR_DUTY_5 14'h249F
`define TACR_DUTY_6 14'h2616
`define TACR_DUTY_7 14'h26AC

// ----------------------------------------
// field value tables
// ----------------------------------------
`define TACR_OLC_BASE     5'h03
`define TACR_BEMF_STEP    13'h00C8
`define TACR_CYC_BASE     5'h02
`define TACR_CYC_STEP     5'h03
`define TACR_ADV_STEP     4'h5
`define TACR_ZCA_0        4'h5
`define TACR_ZCA_1        4'h8
`define TACR_ZCA_2        4'hC
`define TACR_ZCA_3        4'hF
`define TACR_HYST_0       5'h14
`define TACR_HYST_1       5'h0A
`endif

// ### verilog/tacr_duty_decoder.v
`timescale 1ns/1ps
`include "tacr_defines.vh"
module tacr_duty_decoder
(
  input  wire [2:0]  code,
  output reg  [13:0] level
);
  // ----------------------------------------
  // duty code to level
  // ----------------------------------------
  always @*
  begin
    case (code)
      3'h0:    level = `TACR_DUTY_0;
      3'h1:    level = `TACR_DUTY_1;
      3'h2:    level = `TACR_DUTY_2;
      3'h3:    level = `TACR_DUTY_3;
      3'h4:    level = `TACR_DUTY_4;
      3'h5:    level = `TACR_DUTY_5;
      3'h6:    level = `TACR_DUTY_6;
      default: level = `TACR_DUTY_7;
    endcase
  end
endmodule

// ### verilog/tacr_algo_decoder.v
`timescale 1ns/1ps
`include "tacr_defines.vh"
module tacr_algo_decoder
(
  input  wire [31:0] algo_vars,
  output wire [4:0]  transfer_cycles,
  output reg  [6:0]  negative_limit,
  output wire [4:0]  hysteresis,
  output wire [7:0]  positive_limit,
  output wire [12:0] backemf_threshold,
  output wire [4:0]  cycle_threshold,
  output reg  [3:0]  crossing_angle,
  output wire [3:0]  divide
);
  wire [1:0] olc_code;
  wire [2:0] neg_code;
  wire [4:0] bemf_code;
  wire [2:0] cyc_code;
  wire [1:0] zca_code;
  wire [1:0] div_code;

  assign olc_code  = algo_vars[`TACR_OLC_LSB +: 2];
  assign neg_code  = algo_vars[`TACR_NEG_LSB +: 3];
  assign bemf_code = algo_vars[`TACR_BEMF_LSB +: 5];
  assign cyc_code  = algo_vars[`TACR_CYC_LSB +: 3];
  assign zca_code  = algo_vars[`TACR_ZCA_LSB +: 2];
  assign div_code  = algo_vars[`TACR_DIV_LSB +: 2];

  // ----------------------------------------
  // value translation
  // ----------------------------------------
  assign transfer_cycles = `TACR_OLC_BASE << olc_code;
  always @*
  begin
    case (neg_code)
      3'h0:    negative_limit = 7'h00;
      3'h1:    negative_limit = 7'h58;
      3'h2:    negative_limit = 7'h62;
      3'h3:    negative_limit = 7'h6C;
      3'h4:    negative_limit = 7'h76;
      3'h5:    negative_limit = 7'h0A;
      3'h6:    negative_limit = 7'h14;
      default: negative_limit = 7'h1E;
    endcase
  end
  assign hysteresis = algo_vars[`TACR_HYST_BIT] ? `TACR_HYST_1 : `TACR_HYST_0;
  assign positive_limit = {negative_limit[6], negative_limit} + {3'h0, hysteresis};
  assign backemf_threshold = bemf_code * `TACR_BEMF_STEP;
  assign cycle_threshold = `TACR_CYC_BASE + {2'h0, cyc_code} * `TACR_CYC_STEP;
  always @*
  begin
    case (zca_code)
      2'h0:    crossing_angle = `TACR_ZCA_0;
      2'h1:    crossing_angle = `TACR_ZCA_1;
      2'h2:    crossing_angle = `TACR_ZCA_2;
      default: crossing_angle = `TACR_ZCA_3;
    endcase
  end
  assign divide = 4'h1 << div_code;
endmodule

// ### testbench/tacr_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// register bank checker
// ----------------------------------------
module tacr_chk
(
  input wire        clk,
  input wire        reset,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [2:0]  tri_phase_duty_step_three,
  input wire [1:0]  open_loop_transfer_cycles,
  input wire [4:0]  initial_speed_backemf_threshold,
  input wire [12:0] backemf_threshold_value,
  input wire [2:0]  initial_speed_cycle_threshold,
  input wire [4:0]  cycle_threshold_value,
  input wire        surge_guard_hysteresis,
  input wire [4:0]  hysteresis_value,
  input wire [6:0]  negative_limit_value,
  input wire [7:0]  positive_limit_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence acc;
    psel && penable;
  endsequence
  sequence wr_prof;
    acc ##0 (pwrite && paddr == 12'h260);
  endsequence
  sequence wr_algo;
    acc ##0 (pwrite && paddr == 12'h268);
  endsequence
  sequence rd_bad;
    psel && !penable && !pwrite && paddr != 12'h260 && paddr != 12'h268;
  endsequence
  chk_ready_access: assert property (acc |-> pready) else $error("no ready in access");
  chk_ready_idle: assert property (!penable |-> !pready) else $error("ready outside access");
  chk_err_unmapped: assert property (acc ##0 (paddr != 12'h260 && paddr != 12'h268) |-> pslverr)
    else $error("no error on unmapped address");
  chk_bad_read: assert property (rd_bad |=> prdata == 32'h0) else $error("unmapped read not zero");
  chk_step_store: assert property (wr_prof |=> tri_phase_duty_step_three == $past(pwdata[21:19]))
    else $error("step three not stored");
  chk_step_hold: assert property (!(psel && penable && pwrite) |=> $stable(tri_phase_duty_step_three))
    else $error("step three changed without write");
  chk_olc_store: assert property (wr_algo |=> open_loop_transfer_cycles == $past(pwdata[23:22]))
    else $error("transfer cycles not stored");
  chk_cycle_map: assert property (
    cycle_threshold_value == 5'h02 + 5'h03 * $past(initial_speed_cycle_threshold))
    else $error("cycle threshold wrong");
  chk_bemf_map: assert property (
    backemf_threshold_value == 13'h00C8 * $past(initial_speed_backemf_threshold))
    else $error("backemf threshold wrong");
  chk_hyst_map: assert property (
    hysteresis_value == ($past(surge_guard_hysteresis) ? 5'h0A : 5'h14))
    else $error("hysteresis wrong");
  chk_pos_limit: assert property (
    positive_limit_value == {negative_limit_value[6], negative_limit_value} + {3'h0, hysteresis_value})
    else $error("positive limit wrong");
endmodule

bind tacr_config_regs tacr_chk chk_i
(
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .tri_phase_duty_step_three(tri_phase_duty_step_three),
  .open_loop_transfer_cycles(open_loop_transfer_cycles),
  .initial_speed_backemf_threshold(initial_speed_backemf_threshold),
  .backemf_threshold_value(backemf_threshold_value), .initial_speed_cycle_threshold(initial_speed_cycle_threshold),
  .cycle_threshold_value(cycle_threshold_value), .surge_guard_hysteresis(surge_guard_hysteresis),
  .hysteresis_value(hysteresis_value), .negative_limit_value(negative_limit_value),
  .positive_limit_value(positive_limit_value)
);

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, rd;
  int          n_fail = 0, cmp_count = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr, hy;
  wire  [2:0]  st [3:7], ng, cy;
  wire  [13:0] dl [3:7];
  wire  [1:0]  ad, ol, za, dv;
  wire  [3:0]  adeg, zdeg, dval;
  wire  [8:0]  up;
  wire  [4:0]  cnt, hv, bm, cv;
  wire  [6:0]  nv;
  wire  [7:0]  pv;
  wire  [12:0] bv;
  logic [13:0] duty [8] = '{14'h0000, 14'h1388, 14'h1D4C, 14'h20B7, 14'h222E, 14'h249F, 14'h2616, 14'h26AC};
  logic [6:0]  negt [8] = '{7'h00, 7'h58, 7'h62, 7'h6C, 7'h76, 7'h0A, 7'h14, 7'h1E};
  logic [3:0]  zt [4] = '{4'h5, 4'h8, 4'hC, 4'hF};
  always #2 clk = ~clk;
  tacr_config_regs uut
  (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tri_phase_duty_step_three(st[3]),
    .tri_phase_duty_step_four(st[4]), .tri_phase_duty_step_five(st[5]), .tri_phase_duty_step_six(st[6]),
    .tri_phase_duty_step_seven(st[7]), .duty_level_three(dl[3]), .duty_level_four(dl[4]),
    .duty_level_five(dl[5]), .duty_level_six(dl[6]), .duty_level_seven(dl[7]), .wide_mod_angle_advance(ad),
    .advance_degrees(adeg), .upper_duty_steps(up), .open_loop_transfer_cycles(ol), .transfer_cycle_count(cnt),
    .surge_guard_negative_limit(ng), .negative_limit_value(nv), .surge_guard_hysteresis(hy),
    .hysteresis_value(hv), .positive_limit_value(pv), .initial_speed_backemf_threshold(bm),
    .backemf_threshold_value(bv), .initial_speed_cycle_threshold(cy), .cycle_threshold_value(cv),
    .open_loop_crossing_angle(za), .crossing_angle_degrees(zdeg), .quick_start_divide(dv), .divide_value(dval)
  );
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, pready);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge clk);
    #1;
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    apb(1'b0, 12'h260, 32'h0);
    chk("profile reset", 32'h0, rd);
    apb(1'b0, 12'h268, 32'h0);
    chk("algo reset", 32'h0, rd);
    chk("count reset", 32'h3, cnt);
    chk("pos reset", 32'h14, pv);
    chk("cycle reset", 32'h2, cv);
    chk("angle reset", 32'h5, zdeg);
    chk("divide reset", 32'h1, dval);
    $display("reset test done");
  endtask
  task automatic t_profile;
    int k, j;
    logic [31:0] d;
    wr(12'h260, 32'hFFFFFFFF);
    apb(1'b0, 12'h260, 32'h0);
    chk("profile mask", 32'hFFFFFFE0, rd);
    chk("upper steps", 32'h1FF, up);
    for (k = 0; k < 8; k++)
    begin
      d = (k % 4) << 5;
      for (j = 3; j < 8; j++)
        d = d | (((k + j) % 8) << (28 - 3 * j));
      wr(12'h260, d);
      for (j = 3; j < 8; j++)
      begin
        chk("step code", (k + j) % 8, st[j]);
        chk("duty level", duty[(k + j) % 8], dl[j]);
      end
      chk("advance code", k % 4, ad);
      chk("advance", 5 * (k % 4), adeg);
      apb(1'b0, 12'h260, 32'h0);
      chk("profile read", d, rd);
    end
    $display("profile test done");
  endtask
  task automatic t_algo;
    int k, h;
    logic [31:0] d;
    logic [7:0]  pe;
    wr(12'h268, 32'hFFFFFFFF);
    apb(1'b0, 12'h268, 32'h0);
    chk("algo mask", 32'h80C7FF8F, rd);
    for (k = 0; k < 8; k++)
    begin
      h = k % 2;
      d = (h << 31) | ((k % 4) << 22) | (k << 16) | (h << 15) | ((4 * k + 3) << 10) | (k << 7);
      d = d | (((k + 1) % 4) << 2) | ((k + 2) % 4);
      wr(12'h268, d);
      pe = {negt[k][6], negt[k]} + (h ? 8'h0A : 8'h14);
      chk("raw fields", {d[23:22], d[18:7], d[3:0]}, {ol, ng, hy, bm, cy, za, dv});
      chk("transfer count", 3 << (k % 4), cnt);
      chk("neg limit", negt[k], nv);
      chk("hysteresis", h ? 10 : 20, hv);
      chk("pos limit", pe, pv);
      chk("backemf", 200 * (4 * k + 3), bv);
      chk("cycles", 2 + 3 * k, cv);
      chk("angle", zt[(k + 1) % 4], zdeg);
      chk("divide", 1 << ((k + 2) % 4), dval);
      apb(1'b0, 12'h268, 32'h0);
      chk("algo read", d, rd);
    end
    $display("algo test done");
  endtask
  task automatic t_unmapped;
    apb(1'b1, 12'h264, 32'hFFFFFFFF);
    chk("write err", 32'h1, err);
    apb(1'b0, 12'h264, 32'h0);
    chk("unmapped read", 32'h0, rd);
    chk("read err", 32'h1, err);
    apb(1'b0, 12'h260, 32'h0);
    chk("mapped err", 32'h0, err);
    chk("profile kept", 32'h00139760, rd);
    $display("unmapped test done");
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_profile;
    t_algo;
    t_unmapped;
    final_report;
  end
  initial
  begin
    #100000;
    n_fail++;
    final_report;
  end
endmodule
